// *** hdl/blb_byte_lane.sv ***
// cpu byte lane masking toward memory interface and usb, plus rate enable
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module blb_byte_lane (
    // clock, reset, clock enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // cpu access classification and data
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic cpu_to_mem,
    input wire logic cpu_to_memreg,
    input wire logic cpu_to_usbreg,
    input wire logic [15:0] cpu_wdata,
    output logic cpu_busy,
    // external bus width strap, 0 = 8-bit, 1 = 16-bit
    input wire logic ext_bus_width_select,
    // memory side access request
    output logic mem_req,
    output logic mem_we,
    output logic [1:0] mem_lane_en,
    output logic [15:0] mem_wdata,
    output logic mem_second_half,
    // register byte enables toward memory interface and usb
    output logic [1:0] memreg_be,
    output logic [1:0] usbreg_be,
    // memory interface clock enable
    output logic ext_clk_en
);
    logic [1:0] byte_lane_select;
    logic [1:0] usb_lane_select;
    logic ext_clock_full_rate_select;
    logic half_phase;
    logic [1:0] lane_eff;
    logic [1:0] usb_eff;
    logic [15:0] held_wdata;
    logic held_we;
    blb_pkg::blb_state_e state;
    blb_pkg::blb_state_e next_state;

    // reserved code 3 falls back to word mode, so nothing is undefined
    assign lane_eff = (byte_lane_select == blb_pkg::LANE_HIGH ||
                       byte_lane_select == blb_pkg::LANE_LOW)
                      ? byte_lane_select : blb_pkg::LANE_WORD;
    assign usb_eff = (usb_lane_select == blb_pkg::LANE_HIGH ||
                      usb_lane_select == blb_pkg::LANE_LOW)
                     ? usb_lane_select : blb_pkg::LANE_WORD;

    // register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            byte_lane_select <= blb_pkg::LANE_RESET;
            usb_lane_select <= blb_pkg::LANE_RESET;
            ext_clock_full_rate_select <= blb_pkg::FULL_RATE_RESET;
        end else if (ce && reg_wr) begin
            if (reg_addr == blb_pkg::ADDR_LANE_CTRL) begin
                byte_lane_select <= reg_wdata[blb_pkg::LANE_SEL_LSB +: 2];
            end
            if (reg_addr == blb_pkg::ADDR_USB_CTRL) begin
                usb_lane_select <= reg_wdata[blb_pkg::LANE_SEL_LSB +: 2];
            end
            if (reg_addr == blb_pkg::ADDR_CLK_DIV) begin
                ext_clock_full_rate_select <=
                    reg_wdata[blb_pkg::FULL_RATE_BIT];
            end
        end
    end

    // read data one cycle after the strobe; reserved bits read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    blb_pkg::ADDR_LANE_CTRL:
                        reg_rdata <= {14'h0000, byte_lane_select};
                    blb_pkg::ADDR_USB_CTRL:
                        reg_rdata <= {14'h0000, usb_lane_select};
                    blb_pkg::ADDR_CLK_DIV:
                        reg_rdata <=
                            {15'h0000, ext_clock_full_rate_select};
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // rate enable stays in the system domain, avoiding a derived clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half_phase <= 1'b0;
        end else if (ce) begin
            half_phase <= ~half_phase;
        end
    end
    // one enable drives async and sdram timing in the memory interface
    assign ext_clk_en = ce &&
        (ext_clock_full_rate_select || half_phase);

    // register byte enables: only the classified target sees masking
    always_comb begin
        memreg_be = 2'b00;
        usbreg_be = 2'b00;
        if (cpu_req && cpu_to_memreg) begin
            unique case (lane_eff)
                blb_pkg::LANE_HIGH: memreg_be = 2'b10;
                blb_pkg::LANE_LOW: memreg_be = 2'b01;
                default: memreg_be = 2'b11;
            endcase
        end
        if (cpu_req && cpu_to_usbreg) begin
            unique case (usb_eff)
                blb_pkg::LANE_HIGH: usbreg_be = 2'b10;
                blb_pkg::LANE_LOW: usbreg_be = 2'b01;
                default: usbreg_be = 2'b11;
            endcase
        end
    end

    // split sequencer: the cpu is held while the second half is pending
    always_comb begin
        next_state = state;
        unique case (state)
            blb_pkg::BLB_IDLE: begin
                if (cpu_req && cpu_to_mem) begin
                    next_state = blb_pkg::BLB_FIRST;
                end
            end
            blb_pkg::BLB_FIRST: begin
                if (ext_bus_width_select == blb_pkg::BUS_WIDTH_8 &&
                    lane_eff == blb_pkg::LANE_WORD) begin
                    next_state = blb_pkg::BLB_SECOND;
                end else begin
                    next_state = blb_pkg::BLB_IDLE;
                end
            end
            blb_pkg::BLB_SECOND: next_state = blb_pkg::BLB_IDLE;
            default: next_state = blb_pkg::BLB_IDLE;
        endcase
    end

    // sequencer state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= blb_pkg::BLB_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // capture the cpu word at acceptance
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held_wdata <= 16'h0000;
            held_we <= 1'b0;
        end else if (ce && state == blb_pkg::BLB_IDLE &&
                     cpu_req && cpu_to_mem) begin
            held_wdata <= cpu_wdata;
            held_we <= cpu_we;
        end
    end

    // memory request outputs come from flip-flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_lane_en <= 2'b00;
            mem_wdata <= 16'h0000;
            mem_second_half <= 1'b0;
        end else if (ce) begin
            mem_req <= 1'b0;
            mem_second_half <= 1'b0;
            mem_lane_en <= 2'b00;
            if (state == blb_pkg::BLB_IDLE && cpu_req && cpu_to_mem) begin
                mem_req <= 1'b1;
                mem_we <= cpu_we;
                if (ext_bus_width_select == blb_pkg::BUS_WIDTH_8) begin
                    // 8-bit bus: the byte always travels on lane 0
                    mem_lane_en <= 2'b01;
                    mem_wdata <= (lane_eff == blb_pkg::LANE_HIGH)
                                 ? {8'h00, cpu_wdata[15:8]}
                                 : {8'h00, cpu_wdata[7:0]};
                end else begin
                    unique case (lane_eff)
                        blb_pkg::LANE_HIGH: begin
                            mem_lane_en <= 2'b10;
                            mem_wdata <= {cpu_wdata[15:8], 8'h00};
                        end
                        blb_pkg::LANE_LOW: begin
                            mem_lane_en <= 2'b01;
                            mem_wdata <= {8'h00, cpu_wdata[7:0]};
                        end
                        default: begin
                            mem_lane_en <= 2'b11;
                            mem_wdata <= cpu_wdata;
                        end
                    endcase
                end
            end else if (next_state == blb_pkg::BLB_SECOND) begin
                mem_req <= 1'b1;
                mem_we <= held_we;
                mem_lane_en <= 2'b01;
                mem_second_half <= 1'b1;
                mem_wdata <= {8'h00, held_wdata[15:8]};
            end
        end
    end

    assign cpu_busy = (state != blb_pkg::BLB_IDLE);

    // sequencer, lane, byte enable and rate checks
    a_split_two_beats: assert property (@(posedge clk) disable iff (rst)
        (ce && mem_req && !mem_second_half && mem_lane_en == 2'b01 &&
         state == blb_pkg::BLB_FIRST && next_state == blb_pkg::BLB_SECOND)
        |=> (mem_req && mem_second_half))
        else $error("word access on 8-bit bus not split");
    a_high_lane_only: assert property (@(posedge clk) disable iff (rst)
        (ce && state == blb_pkg::BLB_IDLE && cpu_req && cpu_to_mem &&
         ext_bus_width_select && lane_eff == blb_pkg::LANE_HIGH)
        |=> (mem_lane_en == 2'b10))
        else $error("high byte lane not selected");
    a_usb_word_be: assert property (@(posedge clk) disable iff (rst)
        (cpu_req && cpu_to_usbreg && usb_eff == blb_pkg::LANE_WORD)
        |-> usbreg_be == 2'b11)
        else $error("usb word access masked");
    a_memreg_isolated: assert property (@(posedge clk) disable iff (rst)
        (!cpu_to_memreg) |-> memreg_be == 2'b00)
        else $error("memory register enable without target");
    a_half_rate_en: assert property (@(posedge clk) disable iff (rst)
        (ce && $past(ce) && !ext_clock_full_rate_select &&
         !$past(ext_clock_full_rate_select) && ext_clk_en)
        |=> (!ext_clk_en || ext_clock_full_rate_select))
        else $error("half rate enable not alternating");
    a_full_rate_en: assert property (@(posedge clk) disable iff (rst)
        (ce && ext_clock_full_rate_select) |-> ext_clk_en)
        else $error("full rate enable dropped");
    a_reserved_word: assert property (@(posedge clk) disable iff (rst)
        (cpu_req && cpu_to_memreg && byte_lane_select == 2'h3)
        |-> memreg_be == 2'b11)
        else $error("reserved code not word");
    a_single_beat: assert property (@(posedge clk) disable iff (rst)
        (ce && state == blb_pkg::BLB_FIRST && lane_eff != blb_pkg::LANE_WORD)
        |=> state == blb_pkg::BLB_IDLE)
        else $error("byte mode produced extra beat");

    // register enables follow the raw field, so a broken decode shows here
    a_high_reg_be: assert property (@(posedge clk) disable iff (rst)
        (cpu_req && cpu_to_memreg &&
         byte_lane_select == blb_pkg::LANE_HIGH) |-> memreg_be == 2'b10)
        else $error("high byte register enable wrong");
    a_low_reg_be: assert property (@(posedge clk) disable iff (rst)
        (cpu_req && cpu_to_usbreg &&
         usb_lane_select == blb_pkg::LANE_LOW) |-> usbreg_be == 2'b01)
        else $error("low byte usb register enable wrong");
    a_low_memreg_be: assert property (@(posedge clk) disable iff (rst)
        (cpu_req && cpu_to_memreg &&
         byte_lane_select == blb_pkg::LANE_LOW) |-> memreg_be == 2'b01)
        else $error("low byte memory register enable wrong");
    a_usbreg_isolated: assert property (@(posedge clk) disable iff (rst)
        (!cpu_to_usbreg) |-> usbreg_be == 2'b00)
        else $error("usb register enable without target");

    // memory beats one cycle after acceptance; ce is in the antecedent
    // because a low enable freezes the outputs and would hold the beat
    a_word_one_beat: assert property (@(posedge clk) disable iff (rst)
        (ce && state == blb_pkg::BLB_IDLE && cpu_req && cpu_to_mem &&
         ext_bus_width_select && byte_lane_select == blb_pkg::LANE_WORD)
        |=> (mem_req && mem_lane_en == 2'b11 && !mem_second_half))
        else $error("word access on 16-bit bus not one full beat");
    a_low_lane_only: assert property (@(posedge clk) disable iff (rst)
        (ce && state == blb_pkg::BLB_IDLE && cpu_req && cpu_to_mem &&
         ext_bus_width_select && byte_lane_select == blb_pkg::LANE_LOW)
        |=> (mem_lane_en == 2'b01 && mem_wdata[15:8] == 8'h00))
        else $error("low byte lane not selected");
    a_byte_narrow_bus: assert property (@(posedge clk) disable iff (rst)
        (ce && state == blb_pkg::BLB_IDLE && cpu_req && cpu_to_mem &&
         !ext_bus_width_select && lane_eff != blb_pkg::LANE_WORD)
        |=> (mem_req && mem_lane_en == 2'b01 && !mem_second_half))
        else $error("byte access on 8-bit bus not one low beat");
    a_no_stray_beat: assert property (@(posedge clk) disable iff (rst)
        (ce && state == blb_pkg::BLB_IDLE && !(cpu_req && cpu_to_mem))
        |=> !mem_req)
        else $error("memory beat without memory access");

    // register read data: reserved bits always read zero
    a_rdata_reserved: assert property (@(posedge clk) disable iff (rst)
        reg_rdata[15:2] == 14'h0000)
        else $error("reserved read data bits set");
    a_div_read_bit: assert property (@(posedge clk) disable iff (rst)
        ($past(ce) && $past(reg_rd) &&
         $past(reg_addr) == blb_pkg::ADDR_CLK_DIV)
        |-> reg_rdata[15:1] == 15'h0000)
        else $error("divider reserved bits read back set");

    // the half rate phase toggles on every enabled cycle
    a_phase_toggle: assert property (@(posedge clk) disable iff (rst)
        ce |=> half_phase != $past(half_phase))
        else $error("half rate phase stuck");
endmodule : blb_byte_lane
`default_nettype wire

// *** hdl/blb_pkg.sv ***
// constants and types for the byte lane access and memory clock divider glue
// Behaviour
// - memory or usb register access in word mode touches all 16 bits
// - high byte mode register access touches only the upper byte
// - low byte mode register access touches only the lower byte
// - word mode on a 16-bit external bus gives one 16-bit access
// - word mode on an 8-bit external bus gives two 8-bit accesses
// - high byte mode, 16-bit bus: one access, upper lane only
// - low byte mode, 16-bit bus: one access, lower lane only
// - either byte mode on an 8-bit bus gives one 8-bit access
// - memory lane select acts only on external memory and its registers
// - usb lane select acts only on usb register accesses
// - lane select field is bits 1-0; value 3 reserved; upper bits read 0
// - full rate select 1, the reset value, runs memory at system rate
// - full rate select 0 runs memory at half rate
// - selected rate governs asynchronous and sdram timing alike
// - full rate select is bit 0 of divider register; others read 0
package blb_pkg;
    localparam logic [15:0] ADDR_CLK_DIV = 16'h1C26;
    localparam logic [15:0] ADDR_LANE_CTRL = 16'h1C33;
    localparam logic [15:0] ADDR_USB_CTRL = 16'h1C32;
    localparam int LANE_SEL_LSB = 0;
    localparam int FULL_RATE_BIT = 0;
    localparam logic [1:0] LANE_RESET = 2'h0;
    localparam logic FULL_RATE_RESET = 1'b1;
    localparam logic [1:0] LANE_WORD = 2'h0;
    localparam logic [1:0] LANE_HIGH = 2'h1;
    localparam logic [1:0] LANE_LOW = 2'h2;
    localparam logic BUS_WIDTH_8 = 1'b0;
    typedef enum logic [1:0] {BLB_IDLE, BLB_FIRST, BLB_SECOND} blb_state_e;
endpackage : blb_pkg

// *** sim/blb_mem_model.sv ***
// behavioural external memory that logs the write beats it receives
`timescale 1ns/1ps
`default_nettype none
module blb_mem_model (
    // clock and log clear
    input wire logic clk,
    input wire logic clr,
    // access from the block
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [1:0] mem_lane_en,
    input wire logic [15:0] mem_wdata,
    input wire logic mem_second_half,
    // beat log
    output logic [3:0] beats,
    output logic [1:0] lane0,
    output logic [1:0] lane1,
    output logic [15:0] data0,
    output logic [15:0] data1,
    output logic [1:0] halves
);
    logic [15:0] seen;
    // a disabled lane is not latched by the device, so it logs as zero
    assign seen = {mem_lane_en[1] ? mem_wdata[15:8] : 8'h00,
                   mem_lane_en[0] ? mem_wdata[7:0] : 8'h00};
    // log each write beat in arrival order
    always @(posedge clk) begin
        if (clr) begin
            beats <= 4'h0;
            halves <= 2'b00;
        end else if (mem_req && mem_we) begin
            beats <= beats + 4'h1;
            if (beats == 4'h0) begin
                lane0 <= mem_lane_en;
                data0 <= seen;
                halves[0] <= mem_second_half;
            end else begin
                lane1 <= mem_lane_en;
                data1 <= seen;
                halves[1] <= mem_second_half;
            end
        end
    end
endmodule : blb_mem_model
`default_nettype wire

// *** sim/tb_top.sv ***
// testbench for the byte lane and memory clock glue
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((e) !== (a)) begin \
    mismatches++; $display("BAD %s exp %0h got %0h", n, e, a); end end
module tb_top;
    logic clk, rst, ce, reg_wr, reg_rd, cpu_req, cpu_we, to_mem;
    logic to_mreg, to_ureg, width, busy, mreq, mwe, half, clken, clr;
    logic [15:0] reg_addr, reg_wdata, rdata, cpu_wdata, mwdata, d0, d1;
    logic [1:0] lanes, mbe, ube, l0, l1, mbe_s, ube_s, hs;
    logic [3:0] beats;
    int mismatches = 0;
    int cmp_count = 0;
    blb_byte_lane i_blb_byte_lane (.clk(clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .cpu_req(cpu_req),
        .cpu_we(cpu_we), .cpu_to_mem(to_mem), .cpu_to_memreg(to_mreg),
        .cpu_to_usbreg(to_ureg), .cpu_wdata(cpu_wdata), .cpu_busy(busy),
        .ext_bus_width_select(width), .mem_req(mreq), .mem_we(mwe),
        .mem_lane_en(lanes), .mem_wdata(mwdata), .mem_second_half(half),
        .memreg_be(mbe), .usbreg_be(ube), .ext_clk_en(clken));
    blb_mem_model i_blb_mem_model (.clk(clk), .clr(clr), .mem_req(mreq),
        .mem_we(mwe), .mem_lane_en(lanes), .mem_wdata(mwdata),
        .mem_second_half(half), .beats(beats), .lane0(l0), .lane1(l1),
        .data0(d0), .data1(d1), .halves(hs));
    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // one cpu access; byte enables are combinational in the request cycle
    task automatic acc(input logic [2:0] cls);
        int i;
        clr <= 1'b1;
        @(posedge clk) {cpu_req, to_mem, to_mreg, to_ureg} <= {1'b1, cls};
        clr <= 1'b0;
        #1 {mbe_s, ube_s} = {mbe, ube};
        @(posedge clk) {cpu_req, to_mem, to_mreg, to_ureg} <= 4'h0;
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            #1;
            if (busy === 1'b0) break;
        end
        if (i == 10) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : acc
    // reset values, reserved bits and an unmapped place
    task automatic regs_check();
        logic [15:0] d;
        rd(blb_pkg::ADDR_CLK_DIV, d); `CHK("div_rst", 16'h0001, d)
        rd(blb_pkg::ADDR_LANE_CTRL, d); `CHK("lane_rst", 16'h0000, d)
        wr(blb_pkg::ADDR_LANE_CTRL, 16'hFFFF);
        rd(blb_pkg::ADDR_LANE_CTRL, d); `CHK("lane_res", 16'h0003, d)
        wr(16'h1C30, 16'hFFFF);
        rd(16'h1C30, d); `CHK("unmapped", 16'h0000, d)
    endtask : regs_check
    // every lane code against register targets of both selects
    task automatic be_check();
        logic [1:0] e;
        for (int m = 0; m < 4; m++) begin
            e = (m == 1) ? 2'h2 : (m == 2) ? 2'h1 : 2'h3;
            wr(blb_pkg::ADDR_LANE_CTRL, 16'(m));
            wr(blb_pkg::ADDR_USB_CTRL, 16'(3 - m));
            acc(3'b010);
            `CHK("memreg_be", e, mbe_s)
            `CHK("usb_idle", 2'h0, ube_s)
            acc(3'b001);
            e = (m == 2) ? 2'h2 : (m == 1) ? 2'h1 : 2'h3;
            `CHK("usbreg_be", e, ube_s)
            `CHK("mreg_idle", 2'h0, mbe_s)
        end
    endtask : be_check
    // beats, lanes and data for both bus widths and all lane modes
    task automatic mem_check();
        logic [15:0] e;
        logic [1:0] el;
        logic split;
        cpu_wdata <= 16'hC3A5;
        for (int w = 0; w < 2; w++) begin
            for (int m = 0; m < 3; m++) begin
                split = (w == 0 && m == 0);
                width <= w[0];
                wr(blb_pkg::ADDR_LANE_CTRL, 16'(m));
                acc(3'b100);
                `CHK("beats", split ? 4'h2 : 4'h1, beats)
                e = (w == 0) ? {8'h00, (m == 1) ? 8'hC3 : 8'hA5} :
                    {(m != 2) ? 8'hC3 : 8'h00, (m != 1) ? 8'hA5 : 8'h00};
                `CHK("data0", e, d0)
                el = (w == 0 || m == 2) ? 2'h1 : (m == 1) ? 2'h2 : 2'h3;
                `CHK("lane0", el, l0)
                `CHK("halves", split ? 2'h2 : 2'h0, hs)
                if (split) begin
                    `CHK("lane1", 2'h1, l1)
                    `CHK("data1", 16'h00C3, d1)
                end
            end
        end
        // a split read must not show up as a write on either beat
        width <= 1'b0;
        wr(blb_pkg::ADDR_LANE_CTRL, 16'h0000);
        cpu_we <= 1'b0;
        acc(3'b100);
        `CHK("read_beats", 4'h0, beats)
        cpu_we <= 1'b1;
    endtask : mem_check
    // full and half rate enables over eight cycles
    task automatic rate_check();
        int n;
        logic [15:0] d;
        for (int f = 1; f >= 0; f--) begin
            wr(blb_pkg::ADDR_CLK_DIV, {15'h7FFF, f[0]});
            n = 0;
            repeat (8) begin
                @(posedge clk);
                #1 n += int'(clken === 1'b1);
            end
            `CHK("clk_en", f ? 8 : 4, n)
        end
        rd(blb_pkg::ADDR_CLK_DIV, d);
        `CHK("div_res", 16'h0000, d)
    endtask : rate_check
    // low clock enable refuses writes; a mid-run reset restores full rate
    task automatic hold_check();
        logic [15:0] d;
        @(posedge clk) ce <= 1'b0;
        wr(blb_pkg::ADDR_LANE_CTRL, 16'h0001);
        #1 `CHK("clk_en_off", 1'b0, clken)
        @(posedge clk) ce <= 1'b1;
        rd(blb_pkg::ADDR_LANE_CTRL, d); `CHK("frozen", 16'h0000, d)
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(blb_pkg::ADDR_CLK_DIV, d); `CHK("div_rst2", 16'h0001, d)
    endtask : hold_check
    initial begin
        {rst, ce, width, clr} = 4'b1111;
        {reg_wr, reg_rd, cpu_req, cpu_we, to_mem, to_mreg, to_ureg} = 7'h1;
        {reg_addr, reg_wdata, cpu_wdata} = '0;
        cpu_we = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        regs_check();
        be_check();
        mem_check();
        rate_check();
        hold_check();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
